// ==== logic/sfrb_map.vh ====
// Opcodes, address fields, page limits and timing constants of the flash command block
`ifndef SFRB_MAP_VH
`define SFRB_MAP_VH

// Opcodes
`define SFRB_OP_LP_READ    8'h01
`define SFRB_OP_PAGE_READ  8'hD2
`define SFRB_OP_BRD1_FAST  8'hD4
`define SFRB_OP_BRD1_SLOW  8'hD1
`define SFRB_OP_BRD2_FAST  8'hD6
`define SFRB_OP_BRD2_SLOW  8'hD3
`define SFRB_OP_BWR1       8'h84
`define SFRB_OP_BWR2       8'h87
`define SFRB_OP_PGE1       8'h83
`define SFRB_OP_PGE2       8'h86

// Dummy byte counts after the address
`define SFRB_DUMMY_NONE    3'h0
`define SFRB_DUMMY_BUF     3'h1
`define SFRB_DUMMY_PAGE    3'h4

// Address fields, 264-byte layout
`define SFRB_STD_PAGE_MSB  23
`define SFRB_STD_PAGE_LSB  9
`define SFRB_STD_BYTE_MSB  8
// Address fields, 256-byte layout
`define SFRB_BIN_PAGE_MSB  22
`define SFRB_BIN_PAGE_LSB  8
`define SFRB_BIN_BYTE_MSB  7

// Last byte offset of a page or buffer
`define SFRB_LAST_STD      9'h107
`define SFRB_LAST_BIN      9'h0FF

// Timing
`define SFRB_CLK_PERIOD_PS 5000
`define SFRB_EP_TIME_NS    40000

// Reset values
`define SFRB_RST_BYTE      8'h00
`define SFRB_RST_PTR       9'h000

`endif

// ==== logic/sfrb_core.v ====
// Serial flash command engine: SPI slave, continuous and page reads, buffers and page program
`timescale 1ns/1ps
`include "sfrb_map.vh"

module sfrb_core #(
  parameter EP_CYCLES = (`SFRB_EP_TIME_NS * 1000) / `SFRB_CLK_PERIOD_PS
) (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        rst,
  // SPI pins
  input  wire        cs_n,
  input  wire        sck,
  input  wire        si,
  output reg         so,
  output reg         so_oe,
  // Configuration strap
  input  wire        binary_page_mode,
  // Status
  output reg         busy,
  output reg         erase_program_error_flag,
  // Main array port
  output reg         arr_rd_en,
  output reg         arr_erase,
  output reg         arr_we,
  output reg  [23:0] arr_addr,
  output reg  [7:0]  arr_wdata,
  input  wire [7:0]  arr_rdata,
  input  wire        arr_fail
);

  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_OPC   = 3'h1;
  localparam [2:0] ST_ADDR  = 3'h2;
  localparam [2:0] ST_DUMMY = 3'h3;
  localparam [2:0] ST_DOUT  = 3'h4;
  localparam [2:0] ST_DIN   = 3'h5;
  localparam [2:0] ST_ARM   = 3'h6;
  localparam [2:0] ST_SKIP  = 3'h7;

  localparam [2:0] K_CONT = 3'h0;
  localparam [2:0] K_PAGE = 3'h1;
  localparam [2:0] K_BRD  = 3'h2;
  localparam [2:0] K_BWR  = 3'h3;
  localparam [2:0] K_PGM  = 3'h4;

  localparam [1:0] PG_IDLE  = 2'h0;
  localparam [1:0] PG_WRITE = 2'h1;
  localparam [1:0] PG_WAIT  = 2'h2;

  // Result: valid, kind, buffer select, dummy count
  function [7:0] sfrb_decode;
    input [7:0] op;
    begin
      case (op)
        `SFRB_OP_LP_READ:   sfrb_decode = {1'b1, K_CONT, 1'b0, `SFRB_DUMMY_NONE};
        `SFRB_OP_PAGE_READ: sfrb_decode = {1'b1, K_PAGE, 1'b0, `SFRB_DUMMY_PAGE};
        `SFRB_OP_BRD1_FAST: sfrb_decode = {1'b1, K_BRD, 1'b0, `SFRB_DUMMY_BUF};
        `SFRB_OP_BRD1_SLOW: sfrb_decode = {1'b1, K_BRD, 1'b0, `SFRB_DUMMY_NONE};
        `SFRB_OP_BRD2_FAST: sfrb_decode = {1'b1, K_BRD, 1'b1, `SFRB_DUMMY_BUF};
        `SFRB_OP_BRD2_SLOW: sfrb_decode = {1'b1, K_BRD, 1'b1, `SFRB_DUMMY_NONE};
        `SFRB_OP_BWR1:      sfrb_decode = {1'b1, K_BWR, 1'b0, `SFRB_DUMMY_NONE};
        `SFRB_OP_BWR2:      sfrb_decode = {1'b1, K_BWR, 1'b1, `SFRB_DUMMY_NONE};
        `SFRB_OP_PGE1:      sfrb_decode = {1'b1, K_PGM, 1'b0, `SFRB_DUMMY_NONE};
        `SFRB_OP_PGE2:      sfrb_decode = {1'b1, K_PGM, 1'b1, `SFRB_DUMMY_NONE};
        default:            sfrb_decode = 8'h00;
      endcase
    end
  endfunction

  // Next {page, byte} after one byte has been moved
  function [23:0] sfrb_advance;
    input [14:0] page;
    input [8:0]  offs;
    input [2:0]  kind;
    input        bin;
    reg   [8:0]  last;
    begin
      last = bin ? `SFRB_LAST_BIN : `SFRB_LAST_STD;
      if (offs != last)
        sfrb_advance = {page, offs + 9'h001};
      else if (kind == K_CONT)
        sfrb_advance = {page + 15'h0001, `SFRB_RST_PTR};
      else
        sfrb_advance = {page, `SFRB_RST_PTR};
    end
  endfunction

  // Pin synchronisers; stage 0 feeds only stage 1
  reg [1:0] cs_sy;
  reg [2:0] sck_sy;
  reg [1:0] si_sy;
  reg [1:0] bin_sy;

  always @(posedge ref_clk) begin
    if (rst) begin
      cs_sy  <= 2'h3;
      sck_sy <= 3'h0;
      si_sy  <= 2'h0;
      bin_sy <= 2'h0;
    end else begin
      cs_sy  <= {cs_sy[0], cs_n};
      sck_sy <= {sck_sy[1:0], sck};
      si_sy  <= {si_sy[0], si};
      bin_sy <= {bin_sy[0], binary_page_mode};
    end
  end

  wire cs_hi    = cs_sy[1];
  wire sck_rise = sck_sy[1] & ~sck_sy[2];
  wire sck_fall = ~sck_sy[1] & sck_sy[2];
  wire si_bit   = si_sy[1];
  wire bin      = bin_sy[1];

  // SRAM buffers: buffer select in the top index bit
  reg [7:0] bmem [0:1023];

  reg [2:0]  state_reg;
  reg [2:0]  kind_reg;
  reg        sel_reg;
  reg [2:0]  dcnt_reg;
  reg [2:0]  bit_cnt_reg;
  reg [2:0]  obit_reg;
  reg [1:0]  abyte_reg;
  reg [6:0]  sh_in_reg;
  reg [15:0] addr_reg;
  reg [7:0]  sh_out_reg;
  reg [14:0] ptr_page_reg;
  reg [8:0]  ptr_byte_reg;
  reg        fetch_reg;
  reg        f1_reg;
  reg        f2_reg;
  reg        main_src_reg;
  reg [7:0]  buf_q_reg;
  reg [7:0]  next_byte_reg;
  reg [1:0]  pg_state_reg;
  reg        pg_sel_reg;
  reg [14:0] pg_page_reg;
  reg [8:0]  pg_idx_reg;
  reg [8:0]  pg_last_reg;
  reg [31:0] ep_timer_reg;

  wire [7:0]  byte_in = {sh_in_reg, si_bit};
  wire [7:0]  dec     = sfrb_decode(byte_in);
  wire [23:0] full    = {addr_reg, byte_in};
  wire [14:0] a_page  = bin ? full[`SFRB_BIN_PAGE_MSB:`SFRB_BIN_PAGE_LSB]
                            : full[`SFRB_STD_PAGE_MSB:`SFRB_STD_PAGE_LSB];
  wire [8:0]  a_byte  = bin ? {1'b0, full[`SFRB_BIN_BYTE_MSB:0]}
                            : full[`SFRB_STD_BYTE_MSB:0];
  wire [23:0] adv     = sfrb_advance(ptr_page_reg, ptr_byte_reg, kind_reg, bin);
  // Program starts only on a whole-byte boundary after a complete address
  wire        pgm_go  = cs_hi & (state_reg == ST_ARM) & (bit_cnt_reg == 3'h0) & ~busy;

  always @(posedge ref_clk) begin
    if (rst) begin
      state_reg     <= ST_IDLE;
      kind_reg      <= K_CONT;
      sel_reg       <= 1'b0;
      dcnt_reg      <= 3'h0;
      bit_cnt_reg   <= 3'h0;
      obit_reg      <= 3'h0;
      abyte_reg     <= 2'h0;
      sh_in_reg     <= 7'h00;
      addr_reg      <= 16'h0000;
      sh_out_reg    <= `SFRB_RST_BYTE;
      ptr_page_reg  <= 15'h0000;
      ptr_byte_reg  <= `SFRB_RST_PTR;
      fetch_reg     <= 1'b0;
      f1_reg        <= 1'b0;
      f2_reg        <= 1'b0;
      main_src_reg  <= 1'b0;
      buf_q_reg     <= `SFRB_RST_BYTE;
      next_byte_reg <= `SFRB_RST_BYTE;
      pg_state_reg  <= PG_IDLE;
      pg_sel_reg    <= 1'b0;
      pg_page_reg   <= 15'h0000;
      pg_idx_reg    <= `SFRB_RST_PTR;
      pg_last_reg   <= `SFRB_LAST_STD;
      ep_timer_reg  <= 32'h0000_0000;
      so            <= 1'b0;
      so_oe         <= 1'b0;
      busy          <= 1'b0;
      erase_program_error_flag <= 1'b0;
      arr_rd_en     <= 1'b0;
      arr_erase     <= 1'b0;
      arr_we        <= 1'b0;
      arr_addr      <= 24'h000000;
      arr_wdata     <= `SFRB_RST_BYTE;
    end else begin
      fetch_reg <= 1'b0;
      arr_rd_en <= 1'b0;
      arr_erase <= 1'b0;
      arr_we    <= 1'b0;
      f1_reg    <= fetch_reg;
      f2_reg    <= f1_reg;

      // Read pipeline: array answers the cycle after arr_rd_en
      if (fetch_reg) begin
        buf_q_reg <= bmem[{sel_reg, ptr_byte_reg}];
        if (main_src_reg) begin
          arr_rd_en <= 1'b1;
          arr_addr  <= {ptr_page_reg, ptr_byte_reg};
        end
      end
      if (f2_reg)
        next_byte_reg <= main_src_reg ? arr_rdata : buf_q_reg;

      if (cs_hi) begin
        if (state_reg != ST_IDLE) begin
          state_reg <= ST_IDLE;
          so_oe     <= 1'b0;
        end
      end else begin
        case (state_reg)
          ST_IDLE: begin
            state_reg   <= ST_OPC;
            bit_cnt_reg <= 3'h0;
            obit_reg    <= 3'h0;
          end
          default: begin
            if (sck_rise) begin
              sh_in_reg   <= byte_in[6:0];
              bit_cnt_reg <= bit_cnt_reg + 3'h1;
              if (bit_cnt_reg == 3'h7) begin
                case (state_reg)
                  ST_OPC: begin
                    // While busy only buffer reads get through
                    if (!dec[7] || (busy && dec[6:4] != K_BRD)) begin
                      state_reg <= ST_SKIP;
                    end else begin
                      kind_reg     <= dec[6:4];
                      sel_reg      <= dec[3];
                      dcnt_reg     <= dec[2:0];
                      main_src_reg <= (dec[6:4] == K_CONT) || (dec[6:4] == K_PAGE);
                      abyte_reg    <= 2'h0;
                      state_reg    <= ST_ADDR;
                    end
                  end
                  ST_ADDR: begin
                    addr_reg  <= full[15:0];
                    abyte_reg <= abyte_reg + 2'h1;
                    if (abyte_reg == 2'h2) begin
                      ptr_page_reg <= a_page;
                      ptr_byte_reg <= a_byte;
                      if (kind_reg == K_PGM) begin
                        pg_page_reg <= a_page;
                        pg_sel_reg  <= sel_reg;
                        state_reg   <= ST_ARM;
                      end else if (kind_reg == K_BWR) begin
                        state_reg <= ST_DIN;
                      end else if (dcnt_reg != 3'h0) begin
                        state_reg <= ST_DUMMY;
                      end else begin
                        fetch_reg <= 1'b1;
                        state_reg <= ST_DOUT;
                      end
                    end
                  end
                  ST_DUMMY: begin
                    dcnt_reg <= dcnt_reg - 3'h1;
                    if (dcnt_reg == 3'h1) begin
                      fetch_reg <= 1'b1;
                      state_reg <= ST_DOUT;
                    end
                  end
                  ST_DIN: begin
                    bmem[{sel_reg, ptr_byte_reg}] <= byte_in;
                    ptr_byte_reg <= adv[8:0];
                  end
                  default: begin
                  end
                endcase
              end
            end
            // Output shifts on falling clock; next byte is prefetched
            if (sck_fall && state_reg == ST_DOUT) begin
              obit_reg <= obit_reg + 3'h1;
              if (obit_reg == 3'h0) begin
                so           <= next_byte_reg[7];
                sh_out_reg   <= {next_byte_reg[6:0], 1'b0};
                so_oe        <= 1'b1;
                ptr_page_reg <= adv[23:9];
                ptr_byte_reg <= adv[8:0];
                fetch_reg    <= 1'b1;
              end else begin
                so         <= sh_out_reg[7];
                sh_out_reg <= {sh_out_reg[6:0], 1'b0};
              end
            end
          end
        endcase
      end

      // Self-timed erase then program; array core reports failures on arr_fail
      case (pg_state_reg)
        PG_IDLE: begin
          if (pgm_go) begin
            busy         <= 1'b1;
            erase_program_error_flag <= 1'b0;
            arr_erase    <= 1'b1;
            arr_addr     <= {pg_page_reg, `SFRB_RST_PTR};
            pg_idx_reg   <= `SFRB_RST_PTR;
            pg_last_reg  <= bin ? `SFRB_LAST_BIN : `SFRB_LAST_STD;
            ep_timer_reg <= 32'h0000_0000;
            pg_state_reg <= PG_WRITE;
          end
        end
        PG_WRITE: begin
          ep_timer_reg <= ep_timer_reg + 32'h0000_0001;
          arr_we       <= 1'b1;
          arr_addr     <= {pg_page_reg, pg_idx_reg};
          arr_wdata    <= bmem[{pg_sel_reg, pg_idx_reg}];
          pg_idx_reg   <= pg_idx_reg + 9'h001;
          if (pg_idx_reg == pg_last_reg)
            pg_state_reg <= PG_WAIT;
        end
        PG_WAIT: begin
          ep_timer_reg <= ep_timer_reg + 32'h0000_0001;
          if (ep_timer_reg >= EP_CYCLES - 1) begin
            busy         <= 1'b0;
            pg_state_reg <= PG_IDLE;
          end
        end
        default: pg_state_reg <= PG_IDLE;
      endcase
      // Sticky until the next program starts
      if (busy && arr_fail)
        erase_program_error_flag <= 1'b1;
    end
  end

endmodule

// ==== sim/sfrb_array_model.sv ====
// Main array stand-in: patterned reads, recorded erase and page writes
`timescale 1ns/1ps
module sfrb_array_model (
  // Clock
  input  wire        ref_clk,
  // Array port
  input  wire        arr_rd_en,
  input  wire        arr_erase,
  input  wire        arr_we,
  input  wire [23:0] arr_addr,
  input  wire [7:0]  arr_wdata,
  output reg  [7:0]  arr_rdata
);
  reg     [7:0]  mem [0:511];
  reg     [14:0] epage;
  integer        we_cnt;
  initial begin
    arr_rdata = 8'hA5;
    epage = 15'h0000;
    we_cnt = 0;
  end
  // Data only valid the cycle after a strobe; otherwise it keeps changing
  always @(posedge ref_clk) begin
    arr_rdata <= arr_rd_en ? (arr_addr[7:0] ^ arr_addr[16:9]) : ~arr_rdata;
    if (arr_erase) begin
      epage <= arr_addr[23:9];
      we_cnt <= 0;
    end
    if (arr_we) begin
      mem[arr_addr[8:0]] <= arr_wdata;
      we_cnt <= we_cnt + 1;
    end
  end
endmodule

// ==== sim/sfrb_monitor.sv ====
// Port checker for the flash command engine
`timescale 1ns/1ps
module sfrb_monitor #(
  parameter EP_CYCLES = 8000
) (
  input wire        ref_clk,
  input wire        rst,
  input wire        cs_n,
  input wire        sck,
  input wire        si,
  input wire        so,
  input wire        so_oe,
  input wire        binary_page_mode,
  input wire        busy,
  input wire        erase_program_error_flag,
  input wire        arr_rd_en,
  input wire        arr_erase,
  input wire        arr_we,
  input wire [23:0] arr_addr,
  input wire [7:0]  arr_wdata,
  input wire [7:0]  arr_rdata,
  input wire        arr_fail
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  reg [15:0] bcnt_reg;
  reg [15:0] wcnt_reg;
  always @(posedge ref_clk) begin
    if (rst) begin
      bcnt_reg <= 16'h0000;
      wcnt_reg <= 16'h0000;
    end else begin
      bcnt_reg <= busy ? bcnt_reg + 16'h0001 : 16'h0000;
      wcnt_reg <= arr_erase ? 16'h0000 : wcnt_reg + {15'h0000, arr_we};
    end
  end
  sequence s_prog;
    arr_erase ##[1:2] arr_we;
  endsequence
  a_oe_release: assert property (cs_n [*6] |-> !so_oe)
    else $error("output enable kept after deselect");
  a_erase_first: assert property ($rose(busy) |-> ##[0:1] s_prog)
    else $error("program did not start with an erase");
  a_erase_page: assert property (arr_erase |-> arr_addr[8:0] == 9'h000 ##1 !arr_erase)
    else $error("erase not a page-start pulse");
  a_we_busy: assert property ((arr_we || arr_erase) |-> busy)
    else $error("array written while idle");
  a_busy_limit: assert property (busy |-> bcnt_reg <= EP_CYCLES)
    else $error("busy beyond time limit");
  a_we_total: assert property ($fell(busy) |-> (wcnt_reg == 16'h0108 || wcnt_reg == 16'h0100))
    else $error("page write count wrong");
  a_fail_sets: assert property (busy && arr_fail |=> erase_program_error_flag)
    else $error("failure not flagged");
  a_flag_hold: assert property ($fell(erase_program_error_flag) |-> busy)
    else $error("flag cleared outside program start");
endmodule
bind sfrb_core sfrb_monitor #(.EP_CYCLES(EP_CYCLES)) sfrb_monitor_inst (
  .ref_clk(ref_clk), .rst(rst), .cs_n(cs_n), .sck(sck), .si(si), .so(so), .so_oe(so_oe),
  .binary_page_mode(binary_page_mode), .busy(busy), .erase_program_error_flag(erase_program_error_flag),
  .arr_rd_en(arr_rd_en), .arr_erase(arr_erase), .arr_we(arr_we), .arr_addr(arr_addr),
  .arr_wdata(arr_wdata), .arr_rdata(arr_rdata), .arr_fail(arr_fail));

// ==== sim/tb.sv ====
// Self-checking bench for the flash command engine
`timescale 1ns/1ps
module tb;
  reg        ref_clk, rst, cs_n, sck, si, binary_page_mode, arr_fail;
  wire       so, so_oe, busy, erase_program_error_flag, arr_rd_en, arr_erase, arr_we;
  wire [23:0] arr_addr;
  wire [7:0] arr_wdata, arr_rdata;
  integer    err_count, checks_done, n;
  reg  [7:0] r;
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  sfrb_core #(.EP_CYCLES(400)) sfrb_core_inst (
    .ref_clk(ref_clk), .rst(rst), .cs_n(cs_n), .sck(sck), .si(si), .so(so), .so_oe(so_oe),
    .binary_page_mode(binary_page_mode), .busy(busy), .erase_program_error_flag(erase_program_error_flag),
    .arr_rd_en(arr_rd_en), .arr_erase(arr_erase), .arr_we(arr_we), .arr_addr(arr_addr),
    .arr_wdata(arr_wdata), .arr_rdata(arr_rdata), .arr_fail(arr_fail));
  sfrb_array_model sfrb_array_model_inst (
    .ref_clk(ref_clk), .arr_rd_en(arr_rd_en), .arr_erase(arr_erase), .arr_we(arr_we),
    .arr_addr(arr_addr), .arr_wdata(arr_wdata), .arr_rdata(arr_rdata));
  task tick(input integer k);
    repeat (k) @(posedge ref_clk);
  endtask
  task chk(input [8*8:1] nm, input [15:0] e, input [15:0] g);
    checks_done = checks_done + 1;
    if (e !== g) begin
      err_count = err_count + 1;
      $display("mismatch %0s expected %h seen %h", nm, e, g);
    end
  endtask
  // One byte, MSB first; host samples so on the rising edge
  task sb(input [7:0] b);
    integer i;
    for (i = 7; i >= 0; i = i - 1) begin
      si <= b[i];
      tick(6);
      sck <= 1'b1;
      r[i] = so;
      tick(7);
      sck <= 1'b0;
    end
  endtask
  // Chip select stays low through opcode, address and dummies
  task cmd(input [7:0] op, input [23:0] a, input integer nd);
    integer    j;
    reg [31:0] frame;
    frame = {op, a};
    cs_n <= 1'b0;
    tick(4);
    for (j = 0; j < 4 + nd; j = j + 1)
      sb(j < 4 ? frame[31 - 8 * j -: 8] : 8'h00);
  endtask
  task stop;
    tick(6);
    cs_n <= 1'b1;
    tick(8);
    chk("oe_off", 16'h0000, {15'h0000, so_oe});
  endtask
  task rdn(input [7:0] op, input [23:0] a, input integer nd, input [15:0] e);
    reg [15:0] got;
    cmd(op, a, nd);
    sb(8'h00);
    got[15:8] = r;
    sb(8'h00);
    got[7:0] = r;
    chk("oe_on", 16'h0001, {15'h0000, so_oe});
    chk("rd_data", e, got);
    stop;
  endtask
  task t_buf;
    integer k;
    cmd(8'h84, 24'h000105, 0);
    for (k = 1; k <= 4; k = k + 1)
      sb(8'h11 * k);
    stop;
    cmd(8'h87, 24'h000000, 0);
    sb(8'h5A);
    sb(8'hC3);
    stop;
    rdn(8'hD4, 24'h000105, 1, 16'h1122);
    rdn(8'hD1, 24'h000107, 0, 16'h3344);
    rdn(8'hD6, 24'h000000, 1, 16'h5AC3);
    rdn(8'hD3, 24'hFFFE00, 0, 16'h5AC3);
  endtask
  task t_arr;
    rdn(8'h01, 24'h000307, 0, 16'h0602);
    rdn(8'h01, 24'hFFFF07, 0, 16'hF800);
    binary_page_mode <= 1'b1;
    tick(4);
    rdn(8'h01, 24'h000380, 0, 16'h8382);
    rdn(8'hD2, 24'h0005FF, 4, 16'hFA05);
    binary_page_mode <= 1'b0;
    tick(4);
    rdn(8'hD4, 24'h000105, 1, 16'h1122);
  endtask
  task prog(input [7:0] op, input [23:0] a, input fl, input [14:0] pg, input integer cnt, input [7:0] b0);
    cmd(op, a, 0);
    stop;
    n = 0;
    while (busy !== 1'b1 && n < 40) begin
      tick(1);
      n = n + 1;
    end
    chk("busy_on", 16'h0001, {15'h0000, busy});
    arr_fail <= fl;
    tick(1);
    arr_fail <= 1'b0;
    n = 0;
    // A buffer write sent while busy must be dropped
    fork
      while (busy !== 1'b0 && n < 600) begin
        tick(1);
        n = n + 1;
      end
      begin
        cmd(8'h84, 24'h000106, 0);
        sb(8'hEE);
        stop;
      end
    join
    chk("ep_time", 16'h0001, {15'h0000, n >= cnt && n < 400});
    chk("ep_flag", {15'h0000, fl}, {15'h0000, erase_program_error_flag});
    chk("ep_page", {1'b0, pg}, {1'b0, sfrb_array_model_inst.epage});
    chk("we_cnt", cnt[15:0], sfrb_array_model_inst.we_cnt[15:0]);
    chk("pg_b0", {8'h00, b0}, {8'h00, sfrb_array_model_inst.mem[0]});
  endtask
  task t_prog;
    prog(8'h83, 24'h000600, 1'b1, 15'h0003, 264, 8'h44);
    chk("pg_b105", 16'h1122, {sfrb_array_model_inst.mem[9'h105], sfrb_array_model_inst.mem[9'h106]});
    binary_page_mode <= 1'b1;
    tick(4);
    prog(8'h86, 24'h000700, 1'b0, 15'h0007, 256, 8'h5A);
    binary_page_mode <= 1'b0;
    tick(4);
    rdn(8'hD1, 24'h000106, 0, 16'h2233);
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #400000;
    err_count = err_count + 1;
    end_of_test;
  end
  initial begin
    rst = 1'b1;
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    binary_page_mode = 1'b0;
    arr_fail = 1'b0;
    err_count = 0;
    checks_done = 0;
    r = 8'h00;
    tick(8);
    rst <= 1'b0;
    tick(4);
    t_buf;
    t_arr;
    t_prog;
    end_of_test;
  end
endmodule
